// ===== shmx_pkg.sv
// Constants for the handshake line time-division multiplexer.
// Assumes a 125 MHz system clock and a 16-slot serial link.
// How it works
// - The link uses four wires: bit clock, low-active frame sync, data out, data in.
// - The board derives a 10 MHz bit clock and moves one bit per line per clock.
// - Frame sync is low for one bit period in slot 15 and high elsewhere.
// - Data out is driven only by the board and data in only by the module.
// - A frame has sixteen slots; sixteen signals share data in and eight share data out.
// - Data out carries RTS3 DTR3 RTS1 RTS2 RTS4 DTR4 in slots 0-5, DTR1 DTR2 in 9-10.
// - The link runs with nothing visible to software, but freezes when a finished frame finds the receive buffer full.
// - Frame sync changes on the falling edge of the bit clock.
// - Each data out bit is launched on the rising edge of the bit clock.
// - Data in is sampled on the rising edge; the module drives it on that edge.

package shmx_pkg;
	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_MHZ = 125;
	localparam int unsigned BIT_MHZ = 10;
	// Two toggles per bit clock period
	localparam logic [7:0] ACC_INC = 8'(2 * BIT_MHZ);
	localparam logic [8:0] ACC_MOD = 9'(CLK_MHZ);
	// ----------------------------------------------------------------
	// Frame layout
	// ----------------------------------------------------------------
	localparam int unsigned SLOTS = 16;
	localparam logic [3:0] SYNC_SLOT = 4'hF;
	localparam logic [3:0] LAST_SLOT = 4'hF;
	localparam logic [3:0] RESET_SLOT = 4'hF;
	localparam logic RESERVED_BIT = 1'b0;
	// Index i stands for serial port i+1
	localparam logic [3:0] RTS_SLOT [4] = '{4'h2, 4'h3, 4'h0, 4'h4};
	localparam logic [3:0] DTR_SLOT [4] = '{4'h9, 4'hA, 4'h1, 4'h5};
	localparam logic [3:0] CTS_SLOT [4] = '{4'h3, 4'h8, 4'h0, 4'h5};
	localparam logic [3:0] DSR_SLOT [4] = '{4'hB, 4'hE, 4'h1, 4'h6};
	localparam logic [3:0] DCD_SLOT [4] = '{4'hC, 4'hF, 4'h2, 4'h7};
	localparam logic [3:0] RI_SLOT [4] = '{4'hA, 4'hD, 4'h4, 4'h9};
	localparam int unsigned FIFO_DEPTH = 16;
endpackage : shmx_pkg

// ===== shmx_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock domain shared by writer and reader.
`timescale 1ns/1ps
`default_nettype none

module shmx_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 16
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wr_ptr_r;
	logic [AW:0] rd_ptr_r;
	logic push;
	logic pop;

	// Extra pointer bit tells full from empty
	assign in_ready = !((wr_ptr_r[AW] != rd_ptr_r[AW]) &&
		(wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]));
	assign out_valid = (wr_ptr_r != rd_ptr_r);
	assign out_data = mem[rd_ptr_r[AW-1:0]];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ptr_r[AW-1:0]] <= in_data;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
		end else begin
			if (push) begin
				wr_ptr_r <= wr_ptr_r + 1'b1;
			end
			if (pop) begin
				rd_ptr_r <= rd_ptr_r + 1'b1;
			end
		end
	end
endmodule : shmx_fifo

`default_nettype wire

// ===== shmx_mux.sv
// Board end of the handshake line multiplexer link.
// Assumes UART handshake inputs on CLK; link pins leave the chip.
`timescale 1ns/1ps
`default_nettype none

module shmx_mux (
	// Clock and reset
	input wire logic CLK,
	input wire logic RST,
	// Handshake lines from the UARTs, index i is port i+1
	input wire logic [3:0] RTS,
	input wire logic [3:0] DTR,
	// Handshake lines to the UARTs
	output logic [3:0] CTS,
	output logic [3:0] DSR,
	output logic [3:0] DCD,
	output logic [3:0] RI,
	// Consumer may stall updates of the received lines
	input wire logic DRAIN_READY,
	// Link pins
	output logic MUX_BIT_CLOCK,
	output logic MUX_FRAME_SYNC_N,
	output logic MUX_SERIAL_OUT,
	input wire logic MUX_SERIAL_IN
);
	// ----------------------------------------------------------------
	// Bit clock divider
	// ----------------------------------------------------------------
	logic [7:0] acc_r;
	logic [8:0] acc_sum;
	logic tick;
	logic bclk_r;
	logic stall;
	logic rise;
	logic fall;

	assign acc_sum = {1'b0, acc_r} + {1'b0, shmx_pkg::ACC_INC};
	assign tick = !stall && (acc_sum >= shmx_pkg::ACC_MOD);
	assign rise = tick && !bclk_r;
	assign fall = tick && bclk_r;

	// fractional divider
	// Phase accumulator gives 10 MHz on average; half periods of 6 or 7
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			acc_r <= 8'h00;
		end else if (!stall) begin
			if (tick) begin
				acc_r <= 8'(acc_sum - shmx_pkg::ACC_MOD);
			end else begin
				acc_r <= acc_sum[7:0];
			end
		end
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			bclk_r <= 1'b0;
		end else if (tick) begin
			bclk_r <= !bclk_r;
		end
	end

	// ----------------------------------------------------------------
	// Slot counter
	// ----------------------------------------------------------------
	logic [3:0] slot_r;
	logic [3:0] slot_nxt;

	assign slot_nxt = slot_r + 4'h1;

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			slot_r <= shmx_pkg::RESET_SLOT;
		end else if (rise) begin
			slot_r <= slot_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Outbound line
	// ----------------------------------------------------------------
	logic tx_bit;
	logic tx_r;
	logic sync_n_r;

	always_comb begin
		tx_bit = shmx_pkg::RESERVED_BIT;
		for (int i = 0; i < 4; i++) begin
			if (slot_nxt == shmx_pkg::RTS_SLOT[i]) begin
				tx_bit = RTS[i];
			end
			if (slot_nxt == shmx_pkg::DTR_SLOT[i]) begin
				tx_bit = DTR[i];
			end
		end
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			tx_r <= 1'b0;
		end else if (rise) begin
			tx_r <= tx_bit;
		end
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			sync_n_r <= 1'b1;
		end else if (fall) begin
			sync_n_r <= (slot_r != shmx_pkg::SYNC_SLOT);
		end
	end

	assign MUX_BIT_CLOCK = bclk_r;
	assign MUX_FRAME_SYNC_N = sync_n_r;
	assign MUX_SERIAL_OUT = tx_r;

	// ----------------------------------------------------------------
	// Inbound line
	// ----------------------------------------------------------------
	logic din_meta_r;
	logic din_s_r;
	logic [14:0] rx_frame_r;
	logic seen_r;
	logic push_valid_r;
	logic [15:0] push_data_r;
	logic fifo_in_ready;

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			din_meta_r <= 1'b0;
			din_s_r <= 1'b0;
		end else begin
			din_meta_r <= MUX_SERIAL_IN;
			din_s_r <= din_meta_r;
		end
	end

	// per-slot hold register
	// Bit sampled at a rise belongs to the slot that rise ends
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			rx_frame_r <= 15'h0000;
		end else if (rise && slot_r != shmx_pkg::LAST_SLOT) begin
			rx_frame_r[slot_r] <= din_s_r;
		end
	end

	// First wrap after reset closes a partial frame, so it is not pushed
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			seen_r <= 1'b0;
		end else if (rise) begin
			seen_r <= 1'b1;
		end
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			push_valid_r <= 1'b0;
			push_data_r <= 16'h0000;
		end else if (rise && slot_r == shmx_pkg::LAST_SLOT && seen_r) begin
			push_valid_r <= 1'b1;
			push_data_r <= {din_s_r, rx_frame_r};
		end else if (fifo_in_ready) begin
			push_valid_r <= 1'b0;
		end
	end

	// Full buffer freezes the link rather than losing a frame
	assign stall = push_valid_r && !fifo_in_ready;

	logic fifo_out_valid;
	logic [15:0] fifo_out_data;

	shmx_fifo #(
		.WIDTH(shmx_pkg::SLOTS),
		.DEPTH(shmx_pkg::FIFO_DEPTH)
	) u_fifo (
		.clk(CLK),
		.rst(RST),
		.in_valid(push_valid_r),
		.in_ready(fifo_in_ready),
		.in_data(push_data_r),
		.out_valid(fifo_out_valid),
		.out_ready(DRAIN_READY),
		.out_data(fifo_out_data)
	);

	// ----------------------------------------------------------------
	// Received handshake outputs
	// ----------------------------------------------------------------
	// inbound slot map
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			CTS <= 4'h0;
			DSR <= 4'h0;
			DCD <= 4'h0;
			RI <= 4'h0;
		end else if (fifo_out_valid && DRAIN_READY) begin
			for (int i = 0; i < 4; i++) begin
				CTS[i] <= fifo_out_data[shmx_pkg::CTS_SLOT[i]];
				DSR[i] <= fifo_out_data[shmx_pkg::DSR_SLOT[i]];
				DCD[i] <= fifo_out_data[shmx_pkg::DCD_SLOT[i]];
				RI[i] <= fifo_out_data[shmx_pkg::RI_SLOT[i]];
			end
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RST);

	property p_sync_start;
		$fell(sync_n_r) |-> slot_r == shmx_pkg::SYNC_SLOT;
	endproperty
	a_sync_start: assert property (p_sync_start)
		else $error("frame sync asserted outside slot 15");

	property p_sync_span;
		!sync_n_r |-> (slot_r == shmx_pkg::SYNC_SLOT || slot_r == 4'h0);
	endproperty
	a_sync_span: assert property (p_sync_span)
		else $error("frame sync held too long");

	property p_sync_fall;
		$changed(sync_n_r) |-> $fell(bclk_r);
	endproperty
	a_sync_fall: assert property (p_sync_fall)
		else $error("frame sync moved off a falling edge");

	property p_tx_rise;
		$changed(tx_r) |-> $rose(bclk_r);
	endproperty
	a_tx_rise: assert property (p_tx_rise)
		else $error("data out moved off a rising edge");

	property p_half_period;
		$rose(bclk_r) |-> bclk_r [*6];
	endproperty
	a_half_period: assert property (p_half_period)
		else $error("bit clock high phase too short");

	property p_slot_step;
		$rose(bclk_r) |-> slot_r == 4'($past(slot_r) + 4'h1);
	endproperty
	a_slot_step: assert property (p_slot_step)
		else $error("slot did not advance by one");

	property p_reserved_low;
		$rose(bclk_r) && (slot_r inside {4'h6, 4'h7, 4'h8, [4'hB:4'hF]})
			|-> !tx_r;
	endproperty
	a_reserved_low: assert property (p_reserved_low)
		else $error("reserved out slot not low");

	property p_rts3_slot0;
		$rose(bclk_r) && slot_r == 4'h0 |-> tx_r == $past(RTS[2]);
	endproperty
	a_rts3_slot0: assert property (p_rts3_slot0)
		else $error("slot 0 does not carry RTS3");

	property p_rx_hold;
		$rose(bclk_r) && $past(slot_r) != shmx_pkg::LAST_SLOT
			|-> rx_frame_r[$past(slot_r)] == $past(din_s_r);
	endproperty
	a_rx_hold: assert property (p_rx_hold)
		else $error("inbound bit not captured on rise");
endmodule : shmx_mux

`default_nettype wire

// ===== shmx_far_model.sv
// Behavioural far end of the handshake link: demultiplexes board data
// and sends the module's handshake word. Sees only the four link pins.
`timescale 1ns/1ps
`default_nettype none

module shmx_far_model #(
	parameter int DRIVE_DELAY_NS = 30
) (
	// Link pins
	input wire logic bit_clock,
	input wire logic frame_sync_n,
	input wire logic serial_out,
	output logic serial_in,
	// Test side
	input wire logic [15:0] tx_word,
	output logic [15:0] rx_frame
);
	// ----------------------------------------------------------------
	// Slot tracking
	// ----------------------------------------------------------------
	logic [3:0] slot_r = 4'hF;
	logic [15:0] acc_r = 16'h0000;

	initial rx_frame = 16'h0000;
	initial serial_in = 1'b0;

	always @(posedge bit_clock) begin
		if (frame_sync_n === 1'b0)
			slot_r = 4'h0;
		else
			slot_r = slot_r + 4'h1;
		// Late change keeps hold past the board's synchroniser
		#(DRIVE_DELAY_NS) serial_in = tx_word[slot_r];
	end

	always @(negedge bit_clock) begin
		acc_r[slot_r] = serial_out;
		if (slot_r == 4'hF)
			rx_frame = acc_r;
	end
endmodule : shmx_far_model
`default_nettype wire

// ===== tb_top.sv
// Self-checking bench for the board end of the handshake link.
// Assumes the far-end model is compiled before this file.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [3:0] rts = 4'h0;
	logic [3:0] dtr = 4'h0;
	logic drain = 1'b1;
	logic [15:0] tx = 16'h0000;
	logic [3:0] cts, dsr, dcd, ri;
	logic bclk, sync_n, sout, sin;
	logic [15:0] rx;
	int mismatches = 0;
	int total_checks = 0;

	always #4 clk = ~clk;

	shmx_mux u_shmx_mux (.CLK(clk), .RST(rst), .RTS(rts), .DTR(dtr),
		.CTS(cts), .DSR(dsr), .DCD(dcd), .RI(ri), .DRAIN_READY(drain),
		.MUX_BIT_CLOCK(bclk), .MUX_FRAME_SYNC_N(sync_n),
		.MUX_SERIAL_OUT(sout), .MUX_SERIAL_IN(sin));
	shmx_far_model u_shmx_far_model (.bit_clock(bclk),
		.frame_sync_n(sync_n), .serial_out(sout), .serial_in(sin),
		.tx_word(tx), .rx_frame(rx));

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic check(input string what, input logic [15:0] exp,
		input logic [15:0] got);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	// Received lines put back in slot order
	function automatic logic [15:0] hs();
		return {dcd[1], dsr[1], ri[1], dcd[0], dsr[0], ri[0], ri[3], cts[1],
			dcd[3], dsr[3], cts[3], ri[2], cts[0], dcd[2], dsr[2], cts[2]};
	endfunction : hs

	// One frame is sixteen 100 ns bits
	task automatic frames(input int n);
		repeat (n * 200) @(negedge clk);
	endtask : frames

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic test_out_map;
		logic [3:0] pat [3] = '{4'hA, 4'h5, 4'hF};
		for (int i = 0; i < 3; i++) begin
			rts = pat[i];
			dtr = pat[2 - i];
			frames(3);
			check("out frame", {5'h00, dtr[1], dtr[0], 3'h0, dtr[3], rts[3],
				rts[1], rts[0], dtr[2], rts[2]}, rx);
		end
		$display("test out map done");
	endtask : test_out_map

	task automatic test_in_map;
		logic [15:0] pat [3] = '{16'hA5C3, 16'h5A3C, 16'h8001};
		for (int i = 0; i < 3; i++) begin
			tx = pat[i];
			frames(3);
			check("in lines", pat[i], hs());
		end
		$display("test in map done");
	endtask : test_in_map

	task automatic test_sync;
		int cyc = 0;
		int rises = 0;
		int low_rises = 0;
		int half = 0;
		int armed = 0;
		int sf = 0;
		logic pb = bclk;
		logic ps = sync_n;
		repeat (800) begin
			@(negedge clk);
			cyc++;
			half++;
			if (bclk !== pb) begin
				if (armed > 0)
					check("half period", 16'h0001, 16'(half == 6 || half == 7));
				armed = 1;
				half = 0;
				rises += int'(bclk);
				low_rises += int'(bclk & ~sync_n);
			end
			if (sync_n !== ps) begin
				check("sync on fall", 16'h0001, 16'(pb & ~bclk));
				if (sf > 0 && !sync_n) begin
					check("frame cycles", 16'd200, 16'(cyc));
					check("frame rises", 16'd16, 16'(rises));
				end
				if (sf > 0 && sync_n)
					check("sync width", 16'h0001, 16'(low_rises));
				if (!sync_n) begin
					cyc = 0;
					rises = 0;
					low_rises = 0;
					sf = 1;
				end
			end
			pb = bclk;
			ps = sync_n;
		end
		check("sync seen", 16'h0001, 16'(sf));
		$display("test sync done");
	endtask : test_sync

	task automatic test_stall;
		int n = 0;
		logic pb;
		tx = 16'h3C5A;
		frames(3);
		check("lines before stall", 16'h3C5A, hs());
		drain = 1'b0;
		tx = 16'hC3A5;
		frames(20);
		check("held lines", 16'h3C5A, hs());
		pb = bclk;
		repeat (300) begin
			@(negedge clk);
			n += int'(bclk !== pb);
			pb = bclk;
		end
		// Full buffer stops the link
		check("frozen clock", 16'h0000, 16'(n));
		drain = 1'b1;
		frames(20);
		check("drained lines", 16'hC3A5, hs());
		n = 0;
		repeat (200) begin
			@(negedge clk);
			n += int'(bclk !== pb);
			pb = bclk;
		end
		check("clock resumes", 16'h0001, 16'(n > 0));
		$display("test stall done");
	endtask : test_stall

	task automatic print_verdict;
		$display("Checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : print_verdict

	// ----------------------------------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------------------------------
	initial begin
		repeat (10) @(negedge clk);
		check("reset link", 16'h0002, {13'h0000, bclk, sync_n, sout});
		check("reset lines", 16'h0000, {cts, dsr, dcd, ri});
		repeat (10) @(negedge clk);
		rst = 1'b0;
		test_out_map();
		test_in_map();
		test_sync();
		test_stall();
		print_verdict();
	end

	initial begin
		repeat (20000) @(posedge clk);
		mismatches++;
		$display("Watchdog expired");
		print_verdict();
	end
endmodule : tb_top
`default_nettype wire
